// [src/slu_params.svh]
// Offsets, field positions and counts for the string and word load unit.
// Assumes inclusion by bare name from design files only.
`ifndef SLU_PARAMS_SVH
`define SLU_PARAMS_SVH
`define SLU_OFF_CTRL 8'h00
`define SLU_OFF_BASE 8'h04
`define SLU_OFF_INDEX 8'h08
`define SLU_OFF_DISP 8'h0C
`define SLU_OFF_XER 8'h10
`define SLU_OFF_STAT 8'h14
`define SLU_OFF_EA 8'h18
`define SLU_CTRL_START 31
`define SLU_CTRL_REC 24
`define SLU_STAT_BUSY 0
`define SLU_STAT_DONE 1
`define SLU_STAT_ALIGN 2
`define SLU_STAT_MCHK 3
`define SLU_STAT_RSV 4
`define SLU_STAT_CRU 5
`define SLU_FULL_TOTAL 7'h20
`define SLU_LAST_LANE 2'h3
`define SLU_WORD_BYTES 7'h04
`endif

// [src/slu_pkg.sv]
// Types for the string and word load unit.
// Assumes nothing beyond a SystemVerilog compiler.
package slu_pkg;
    typedef enum logic [3:0] {
        OP_LSI = 4'h0, OP_LSX = 4'h1, OP_LRSV = 4'h2, OP_LBR = 4'h3,
        OP_LWD = 4'h4, OP_LWDU = 4'h5, OP_LWX = 4'h6, OP_LWXU = 4'h7,
        OP_STCND = 4'h8
    } op_e;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, ST_FETCH = 5'h02, ST_WRITE = 5'h04, ST_UPD = 5'h08, ST_PROBE = 5'h10
    } state_e;
endpackage

// [src/string_and_word_load_unit.sv]
// Load unit for string loads, reservation, byte-reversed and word loads.
// Assumes an AXI4-Lite master, a same-clock byte memory port and a
// register file write port; base and index contents arrive by register.
//
// Summary of operation
// - Immediate string EA: zero or base only.
// - Byte count field zero means 32 bytes.
// - Four bytes per register, MSB first.
// - Bits after last byte read zero.
// - Registers advance, wrap 31 to 0.
// - Immediate form skips base register unless last.
// - Indexed string total from exception register count.
// - Indexed EA is index plus base-or-zero.
// - Indexed form skips base and index unless last.
// - Zero indexed count is a no-op.
// - Zero count still flags machine check.
// - Record bit leaves condition field zero undefined.
// - Reserving load writes word, sets flag.
// - Only reserving load sets; conditional store clears.
// - Reserving load misaligned raises alignment exception.
// - Byte-reversed load puts first byte lowest.
// - Displacement sign-extended 16 to 32 bits.
// - Plain word load stores word unchanged.
// - Updating load writes EA to base register.
`timescale 1ns/10ps
`include "slu_params.svh"

module string_and_word_load_unit #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_err,
    input wire logic mem_cacheable,
    input wire logic mem_miss,
    output logic gpr_we,
    output logic [4:0] gpr_idx,
    output logic [31:0] gpr_wdata
);
    // ------------------------------------------------------------
    // Software-visible state
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, base_q, index_q, disp_q, xer_q, ea_q;
    logic busy_q, done_q, align_q, mchk_q, rsv_q, cru_q;
    logic [ADDR_W-1:0] awaddr_q, araddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic start_q;

    slu_pkg::state_e state_q;
    slu_pkg::op_e op_q;
    logic [4:0] rt_q, ra_q, rb_q, r_q, rfin_q;
    logic [6:0] n_q;
    logic [1:0] lane_q;
    logic [31:0] acc_q;
    logic skip_q;
    logic fin_align, fin_mchk, fin_done;

    wire logic [3:0] c_op = ctrl_q[3:0];
    wire logic [4:0] c_rt = ctrl_q[8:4];
    wire logic [4:0] c_ra = ctrl_q[13:9];
    wire logic [4:0] c_rb = ctrl_q[18:14];
    wire logic [4:0] c_nb = ctrl_q[23:19];
    wire logic [6:0] transfer_byte_count = xer_q[6:0];
    wire logic wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire logic [ADDR_W-1:0] woff = awaddr_q & ~ADDR_W'(3);

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (woff <= ADDR_W'(`SLU_OFF_STAT)) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Writes to the control word while busy are dropped so a running
    // instruction never sees its fields change under it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 32'h0000_0000;
            base_q <= 32'h0000_0000;
            index_q <= 32'h0000_0000;
            disp_q <= 32'h0000_0000;
            xer_q <= 32'h0000_0000;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_go && !busy_q) begin
                unique case (woff)
                    ADDR_W'(`SLU_OFF_CTRL): begin
                        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h01FF_FFFF;
                        start_q <= wstrb_q[3] && wdata_q[`SLU_CTRL_START];
                    end
                    ADDR_W'(`SLU_OFF_BASE): base_q <= merge(base_q, wdata_q, wstrb_q);
                    ADDR_W'(`SLU_OFF_INDEX): index_q <= merge(index_q, wdata_q, wstrb_q);
                    ADDR_W'(`SLU_OFF_DISP): disp_q <= merge(disp_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
                    ADDR_W'(`SLU_OFF_XER): xer_q <= merge(xer_q, wdata_q, wstrb_q) & 32'h0000_007F;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (araddr_q & ~ADDR_W'(3))
            ADDR_W'(`SLU_OFF_CTRL): rd_mux = ctrl_q;
            ADDR_W'(`SLU_OFF_BASE): rd_mux = base_q;
            ADDR_W'(`SLU_OFF_INDEX): rd_mux = index_q;
            ADDR_W'(`SLU_OFF_DISP): rd_mux = disp_q;
            ADDR_W'(`SLU_OFF_XER): rd_mux = xer_q;
            ADDR_W'(`SLU_OFF_STAT): rd_mux = {26'h0, cru_q, rsv_q, mchk_q, align_q, done_q, busy_q};
            ADDR_W'(`SLU_OFF_EA): rd_mux = ea_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    logic ar_held_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held_q <= 1'b0;
            s_axi_arready <= 1'b1;
            araddr_q <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_held_q <= 1'b1;
                s_axi_arready <= 1'b0;
                araddr_q <= s_axi_araddr;
            end else if (ar_held_q && !s_axi_rvalid) begin
                ar_held_q <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= ((araddr_q & ~ADDR_W'(3)) <= ADDR_W'(`SLU_OFF_EA)) ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Effective address and byte total
    // ------------------------------------------------------------
    logic [31:0] base_or_zero, ea_calc;
    logic [6:0] total;
    logic is_str, is_upd;
    always_comb begin
        is_upd = (c_op == slu_pkg::OP_LWDU) || (c_op == slu_pkg::OP_LWXU);
        is_str = (c_op == slu_pkg::OP_LSI) || (c_op == slu_pkg::OP_LSX);
        base_or_zero = (c_ra == 5'h00 && !is_upd) ? 32'h0000_0000 : base_q;
        unique case (c_op)
            slu_pkg::OP_LSI: ea_calc = base_or_zero;
            slu_pkg::OP_LWD, slu_pkg::OP_LWDU: ea_calc = base_or_zero + {{16{disp_q[15]}}, disp_q[15:0]};
            default: ea_calc = base_or_zero + index_q;
        endcase
        if (c_op == slu_pkg::OP_LSI) begin
            total = (c_nb == 5'h00) ? `SLU_FULL_TOTAL : {2'h0, c_nb};
        end else if (c_op == slu_pkg::OP_LSX) begin
            total = transfer_byte_count;
        end else begin
            total = `SLU_WORD_BYTES;
        end
    end

    // Last register of a string: target plus ceil(total/4) minus one, mod 32
    wire logic [6:0] regs_used = (total + 7'h03) >> 2;
    wire logic [4:0] rfin_calc = c_rt + regs_used[4:0] - 5'h01;

    // A string register is written unless it is the base, or for the indexed form the index,
    // and is not the final register.
    function automatic logic skip_reg(input logic [4:0] r, input slu_pkg::op_e op,
                                      input logic [4:0] ra, input logic [4:0] rb, input logic [4:0] rf);
        logic hit;
        hit = 1'b0;
        if (op == slu_pkg::OP_LSI) begin
            hit = (r == ra);
        end else if (op == slu_pkg::OP_LSX) begin
            hit = (r == ra) || (r == rb);
        end
        return hit && (r != rf);
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wire logic last_byte = (n_q == 7'h01);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= slu_pkg::ST_IDLE;
            op_q <= slu_pkg::OP_LSI;
            rt_q <= 5'h00;
            ra_q <= 5'h00;
            rb_q <= 5'h00;
            r_q <= 5'h00;
            rfin_q <= 5'h00;
            n_q <= 7'h00;
            lane_q <= 2'h0;
            acc_q <= 32'h0000_0000;
            skip_q <= 1'b0;
            ea_q <= 32'h0000_0000;
            mem_req <= 1'b0;
            mem_addr <= 32'h0000_0000;
            gpr_we <= 1'b0;
            gpr_idx <= 5'h00;
            gpr_wdata <= 32'h0000_0000;
            busy_q <= 1'b0;
            fin_align <= 1'b0;
            fin_mchk <= 1'b0;
            fin_done <= 1'b0;
        end else begin
            gpr_we <= 1'b0;
            fin_align <= 1'b0;
            fin_mchk <= 1'b0;
            fin_done <= 1'b0;
            unique case (state_q)
                slu_pkg::ST_IDLE: begin
                    if (start_q) begin
                        op_q <= slu_pkg::op_e'(c_op);
                        rt_q <= c_rt;
                        ra_q <= c_ra;
                        rb_q <= c_rb;
                        r_q <= c_rt;
                        rfin_q <= rfin_calc;
                        n_q <= total;
                        lane_q <= 2'h0;
                        acc_q <= 32'h0000_0000;
                        skip_q <= skip_reg(c_rt, slu_pkg::op_e'(c_op), c_ra, c_rb, rfin_calc);
                        ea_q <= ea_calc;
                        mem_addr <= ea_calc;
                        if (c_op == slu_pkg::OP_STCND) begin
                            fin_done <= 1'b1;
                        end else if (c_op == slu_pkg::OP_LRSV && ea_calc[1:0] != 2'h0) begin
                            fin_align <= 1'b1;
                            fin_done <= 1'b1;
                        end else if (is_str && total == 7'h00) begin
                            // Probe is still issued; its data is dropped and no register changes
                            mem_req <= 1'b1;
                            busy_q <= 1'b1;
                            state_q <= slu_pkg::ST_PROBE;
                        end else begin
                            mem_req <= 1'b1;
                            busy_q <= 1'b1;
                            state_q <= slu_pkg::ST_FETCH;
                        end
                    end
                end
                slu_pkg::ST_PROBE: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        fin_mchk <= mem_err && mem_cacheable && mem_miss;
                        fin_done <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= slu_pkg::ST_IDLE;
                    end
                end
                slu_pkg::ST_FETCH: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        acc_q[8*(3-lane_q) +: 8] <= mem_rdata;
                        n_q <= n_q - 7'h01;
                        lane_q <= lane_q + 2'h1;
                        mem_addr <= mem_addr + 32'h0000_0001;
                        if (last_byte || lane_q == `SLU_LAST_LANE) begin
                            state_q <= slu_pkg::ST_WRITE;
                        end else begin
                            mem_req <= 1'b1;
                        end
                    end
                end
                slu_pkg::ST_WRITE: begin
                    gpr_idx <= r_q;
                    if (op_q == slu_pkg::OP_LBR) begin
                        gpr_wdata <= {acc_q[7:0], acc_q[15:8], acc_q[23:16], acc_q[31:24]};
                    end else begin
                        gpr_wdata <= acc_q;
                    end
                    gpr_we <= !skip_q;
                    acc_q <= 32'h0000_0000;
                    lane_q <= 2'h0;
                    r_q <= r_q + 5'h01;
                    skip_q <= skip_reg(r_q + 5'h01, op_q, ra_q, rb_q, rfin_q);
                    if (n_q != 7'h00) begin
                        mem_req <= 1'b1;
                        state_q <= slu_pkg::ST_FETCH;
                    end else if (op_q == slu_pkg::OP_LWDU || op_q == slu_pkg::OP_LWXU) begin
                        state_q <= slu_pkg::ST_UPD;
                    end else begin
                        fin_done <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= slu_pkg::ST_IDLE;
                    end
                end
                slu_pkg::ST_UPD: begin
                    gpr_we <= 1'b1;
                    gpr_idx <= ra_q;
                    gpr_wdata <= ea_q;
                    fin_done <= 1'b1;
                    busy_q <= 1'b0;
                    state_q <= slu_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= slu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags: hardware set wins over a same-cycle clear
    // ------------------------------------------------------------
    wire logic stat_clr = wr_go && woff == ADDR_W'(`SLU_OFF_STAT) && wstrb_q[0];
    wire logic [31:0] clr_bits = stat_clr ? wdata_q : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            align_q <= 1'b0;
            mchk_q <= 1'b0;
            cru_q <= 1'b0;
        end else begin
            done_q <= fin_done || (done_q && !clr_bits[`SLU_STAT_DONE]);
            align_q <= fin_align || (align_q && !clr_bits[`SLU_STAT_ALIGN]);
            mchk_q <= fin_mchk || (mchk_q && !clr_bits[`SLU_STAT_MCHK]);
            // Condition field zero is left undefined; software is told so by this flag
            cru_q <= (fin_done && ctrl_q[`SLU_CTRL_REC] && op_q != slu_pkg::OP_STCND)
                     || (cru_q && !clr_bits[`SLU_STAT_CRU]);
        end
    end

    // Reservation: set only by the reserving load, cleared by a conditional store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsv_q <= 1'b0;
        end else if (fin_done && op_q == slu_pkg::OP_LRSV && !fin_align) begin
            rsv_q <= 1'b1;
        end else if (fin_done && op_q == slu_pkg::OP_STCND) begin
            rsv_q <= 1'b0;
        end
    end
endmodule

// [testbench/byte_memory_model.sv]
// Byte memory behind the unit's fetch port.
// Assumes the unit's clock; answers each request after zero to three idle cycles.
`timescale 1ns/10ps

module byte_memory_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic slow,
    input wire logic bus_fault,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    output logic mem_err,
    output logic mem_cacheable,
    output logic mem_miss
);
    logic [2:0] wait_q;

    // ----------------------------------------
    // Answer logic
    // ----------------------------------------
    // Idle lines churn so a stale byte shows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_ack <= 1'b0;
            wait_q <= 3'h0;
            mem_rdata <= 8'h55;
            {mem_err, mem_cacheable, mem_miss} <= 3'h0;
        end else if (mem_req && !mem_ack && wait_q == 3'h0) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C;
            {mem_err, mem_cacheable, mem_miss} <= {3{bus_fault}};
            wait_q <= slow ? {1'b0, mem_addr[1:0]} + 3'h1 : 3'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            {mem_err, mem_cacheable, mem_miss} <= 3'h5 ^ {mem_err, mem_cacheable, mem_miss};
            if (mem_req && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule

// [testbench/string_and_word_load_unit_checker.sv]
// Port checker for the string and word load unit.
// Assumes it is bound onto the unit and shares its single clock.
`timescale 1ns/10ps

module string_and_word_load_unit_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic gpr_we,
    input wire logic [4:0] gpr_idx
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request moved");
    AST_ADDR_STEP: assert property (mem_req && mem_ack ##1 mem_req |-> mem_addr == $past(mem_addr) + 32'h1)
        else $error("address step");
    AST_RST_QUIET: assert property (disable iff (1'b0) !aresetn |=> !mem_req && !gpr_we && !s_axi_bvalid)
        else $error("busy after reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read late");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write late");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while rvalid");
    AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h6
        |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read");

    cover property (mem_req && mem_ack && mem_err);
    cover property (gpr_we && gpr_idx == 5'h0);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind string_and_word_load_unit string_and_word_load_unit_checker #(.ADDR_W(ADDR_W)) u_checker (.*);

// [testbench/string_and_word_load_unit_tb.sv]
// Self-checking bench for the string and word load unit.
// Assumes the byte memory model and the bound port checker.
`timescale 1ns/10ps

module string_and_word_load_unit_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, bus_fault, rsv;
    logic awready, wready, bvalid, arready, rvalid, mem_req, mem_ack, mem_err, mem_cacheable, mem_miss, gpr_we;
    logic [7:0] awaddr, araddr, mem_rdata;
    logic [31:0] wdata, rdata, mem_addr, gpr_wdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [4:0] gpr_idx;
    logic [4:0] nbs[4] = '{5'h01, 5'h04, 5'h05, 5'h1F};
    logic [31:0] got_i[$], got_d[$];
    int failures, comparisons, seed, n;

    string_and_word_load_unit dut (.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .*);
    byte_memory_model mem (.*);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (gpr_we === 1'b1) begin
            got_i.push_back({27'h0, gpr_idx});
            got_d.push_back(gpr_wdata);
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [7:0] mb(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, arvalid} <= {wr, wr, !wr};
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            if (wr ? bvalid : rvalid) begin
                resp = wr ? bresp : rresp;
                if (!wr) rd = rdata;
                break;
            end
        end
        if (k == 64) begin
            check("bus wait", 32'h0, 32'h1);
            report_and_stop();
        end
    endtask

    task automatic run_op(input slu_pkg::op_e op, input logic [4:0] rt, input logic [4:0] ra, input logic [4:0] rb,
                          input logic [4:0] nb, input logic [31:0] base, input logic [31:0] idx,
                          input logic [31:0] disp, input logic [31:0] fixed_point_exception_register);
        logic [31:0] ea, w, e_i[$], e_d[$];
        logic al;
        int cnt, k;
        al = 1'b0;
        w = 32'h0;
        slow <= 1'($random(seed));
        ea = (ra == 5'h0) ? 32'h0 : base;
        if (!(op inside {slu_pkg::OP_LSI, slu_pkg::OP_LWD, slu_pkg::OP_LWDU}))
            ea = ea + idx;
        if (op inside {slu_pkg::OP_LWD, slu_pkg::OP_LWDU})
            ea = ea + {{16{disp[15]}}, disp[15:0]};
        cnt = (op == slu_pkg::OP_LSX) ? int'(fixed_point_exception_register[6:0]) : (op != slu_pkg::OP_LSI) ? 0 : (nb == 5'h0) ? 32 : int'(nb);
        for (k = 0; k < cnt; k++) begin
            w[31 - 8 * (k % 4) -: 8] = mb(ea + k);
            if (k % 4 == 3 || k == cnt - 1) begin
                e_i.push_back((rt + k / 4) % 32);
                e_d.push_back(w);
                w = 32'h0;
            end
        end
        if (op == slu_pkg::OP_LRSV && ea[1:0] != 2'h0) begin
            al = 1'b1;
        end else if (op inside {[slu_pkg::OP_LRSV:slu_pkg::OP_LWXU]}) begin
            w = {mb(ea), mb(ea + 1), mb(ea + 2), mb(ea + 3)};
            e_i.push_back(rt);
            e_d.push_back(op == slu_pkg::OP_LBR ? {mb(ea + 3), mb(ea + 2), mb(ea + 1), mb(ea)} : w);
            if (op inside {slu_pkg::OP_LWDU, slu_pkg::OP_LWXU}) begin
                e_i.push_back(ra);
                e_d.push_back(ea);
            end
            if (op == slu_pkg::OP_LRSV) rsv = 1'b1;
        end
        if (op == slu_pkg::OP_STCND) rsv = 1'b0;
        got_i.delete();
        got_d.delete();
        bus(1'b1, 8'h04, base);
        bus(1'b1, 8'h08, idx);
        bus(1'b1, 8'h0C, disp);
        bus(1'b1, 8'h10, fixed_point_exception_register);
        bus(1'b1, 8'h00, {1'b1, 6'h0, 1'($random(seed)), nb, rb, ra, rt, op});
        rd = 32'h0;
        for (k = 0; k < 100 && rd[1] !== 1'b1; k++) bus(1'b0, 8'h14, 32'h0);
        check("status", rd[4:0], {rsv, op == slu_pkg::OP_LSX && cnt == 0 && bus_fault, al, 2'h2});
        check("write count", got_i.size(), e_i.size());
        for (k = 0; k < e_i.size() && k < got_i.size(); k++) begin
            check("register index", got_i[k], e_i[k]);
            check("register data", got_d[k], e_d[k]);
        end
        bus(1'b0, 8'h18, 32'h0);
        if (op != slu_pkg::OP_STCND) check("effective address", rd, ea);
        bus(1'b1, 8'h14, 32'h0000003F);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, arvalid, slow, bus_fault, rsv} = 7'h0;
        {bready, rready, wstrb, awaddr, araddr, wdata} = {6'h3F, 48'h0};
        {failures, comparisons, rd} = 0;
        seed = 32'hADCFF064;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(1'b0, 8'h14, 32'h0);
        check("status at reset", rd, 32'h0);
        bus(1'b0, 8'h1C, 32'h0);
        check("unmapped read", {rd[29:0], resp}, 32'h2);
        run_op(slu_pkg::OP_LSI, 5'h1C, 5'h05, 5'h00, 5'h00, $random(seed), 0, 0, 0);
        run_op(slu_pkg::OP_LSI, 5'h03, 5'h00, 5'h00, 5'h07, $random(seed), 0, 0, 0);
        for (n = 0; n < 4; n++) run_op(slu_pkg::OP_LSI, 5'h0A, 5'h01, 5'h00, nbs[n], $random(seed), 0, 0, 0);
        run_op(slu_pkg::OP_LSX, 5'h14, 5'h02, 5'h03, 5'h00, $random(seed), $random(seed), 0, 32'h9);
        run_op(slu_pkg::OP_LSX, 5'h1E, 5'h00, 5'h03, 5'h00, 0, $random(seed), 0, 32'h6);
        bus_fault <= 1'b1;
        run_op(slu_pkg::OP_LSX, 5'h14, 5'h02, 5'h03, 5'h00, $random(seed), 0, 0, 32'h0);
        bus_fault <= 1'b0;
        run_op(slu_pkg::OP_LRSV, 5'h07, 5'h02, 5'h03, 5'h00, 32'h100, 32'h24, 0, 0);
        run_op(slu_pkg::OP_LRSV, 5'h07, 5'h02, 5'h03, 5'h00, 32'h100, 32'h26, 0, 0);
        run_op(slu_pkg::OP_STCND, 5'h07, 5'h02, 5'h03, 5'h00, 0, 0, 0, 0);
        for (n = 0; n < 10; n++) run_op(slu_pkg::op_e'(3 + n % 5), 5'h09, 5'h04, 5'h06, 5'h00, $random(seed),
                                        $random(seed), $random(seed), 0);
        report_and_stop();
    end
endmodule
